// [design/spi_flash_cmd.sv]
// serial flash command decoder, read data path and page program buffer
`timescale 1ns/10ps
module spi_flash_cmd
    import spi_flash_pkg::*;
#(
    parameter int PROG_WAIT_CYC = 64
) (
    input  wire logic        i_ref_clk,
    input  wire logic        i_rst_b,
    input  wire logic        i_sclk,
    input  wire logic        i_cs_b,
    input  wire logic [3:0]  i_dq,
    output logic      [3:0]  o_dq,
    output logic      [3:0]  o_dq_oe,
    input  wire logic        i_quad_io_enable_bit,
    input  wire logic        i_page_protected,
    output logic      [23:0] o_flash_addr,
    input  wire logic [7:0]  i_rd_data,
    output logic             o_prog_valid,
    output logic      [23:0] o_prog_addr,
    output logic      [7:0]  o_prog_data,
    input  wire logic        i_prog_ready,
    output logic             o_busy,
    output logic             o_write_enable_latch,
    output logic      [2:0]  o_wrap_setting
);
    // ========================================
    // state record
    typedef struct packed {
        logic [2:0]        sclk_sy;
        logic [2:0]        cs_sy;
        logic [3:0]        dq_s1;
        logic [3:0]        dq_s2;
        phase_e            st;
        logic [7:0]        cmd;
        logic [2:0]        in_w;
        logic [2:0]        out_w;
        logic [3:0]        dum;
        logic              mode;
        logic [5:0]        cnt;
        logic [7:0]        sh;
        logic [23:0]       addr;
        logic [7:0]        out_sh;
        logic [3:0]        dq_o;
        logic [3:0]        dq_oe;
        logic              src_st;
        logic              write_enable_latch;
        logic [2:0]        wrap;
        logic [255:0][7:0] pb;
        logic [255:0]      ld;
        logic              any;
        logic              prog_act;
        logic [8:0]        walk;
        logic [15:0]       wait_c;
        logic [15:0]       page;
        logic [1:0][31:0]  fb;
        logic [1:0]        fcnt;
        logic              frd;
        logic              fwr;
    } state_s;

    state_s     q;
    state_s     d;
    logic       rise;
    logic       fall;
    logic       cs_rise;
    logic       cmd_done;
    logic [7:0] code;
    logic [7:0] wmask;
    logic [7:0] status;
    logic       push;
    logic       pop;
    logic [7:0] byte_v;

    // ========================================
    // helpers
    function automatic logic [5:0] edges_for(input logic [2:0] w, input logic [5:0] bits);
        case (w)
            LANE_4:  return bits >> 2;
            LANE_2:  return bits >> 1;
            default: return bits;
        endcase
    endfunction

    function automatic logic [23:0] shift_in(input logic [23:0] a, input logic [2:0] w,
                                             input logic [3:0] v);
        case (w)
            LANE_4:  return {a[19:0], v};
            LANE_2:  return {a[21:0], v[1:0]};
            default: return {a[22:0], v[0]};
        endcase
    endfunction

    // upper bits of the byte go out first; line 3 carries the top bit in quad
    function automatic logic [3:0] lanes(input logic [7:0] b, input logic [2:0] w);
        case (w)
            LANE_4:  return b[7:4];
            LANE_2:  return {2'b00, b[7:6]};
            default: return {2'b00, b[7], 1'b0};
        endcase
    endfunction

    function automatic logic [3:0] oe_for(input logic [2:0] w);
        case (w)
            LANE_4:  return OE_QUAD;
            LANE_2:  return OE_DUAL;
            default: return OE_SINGLE;
        endcase
    endfunction

    // ========================================
    // edges of the synchronised link signals
    assign rise     = q.sclk_sy[1] & ~q.sclk_sy[2] & ~q.cs_sy[1];
    assign fall     = ~q.sclk_sy[1] & q.sclk_sy[2] & ~q.cs_sy[1];
    assign cs_rise  = q.cs_sy[1] & ~q.cs_sy[2];
    assign cmd_done = rise && q.st == S_CMD && q.cnt == CODE_BITS - 6'h01;
    assign code     = {q.sh[6:0], q.dq_s2[0]};
    assign wmask    = 8'((WRAP_MIN << q.wrap[2:1]) - 8'h01);
    assign status   = 8'({q.write_enable_latch, 1'b0} | {1'b0, q.prog_act});
    assign pop      = (q.fcnt != 2'h0) && i_prog_ready;

    // ========================================
    // next state
    always_comb begin
        d      = q;
        push   = 1'b0;
        byte_v = q.out_sh;
        // two-stage synchronisers on every pin input
        d.sclk_sy = {q.sclk_sy[1:0], i_sclk};
        d.cs_sy   = {q.cs_sy[1:0], i_cs_b};
        d.dq_s1   = i_dq;
        d.dq_s2   = q.dq_s1;
        if (q.cs_sy[1]) begin
            // select high ends or aborts whatever was in flight
            d.st    = S_CMD;
            d.cnt   = 6'h00;
            d.dq_oe = 4'h0;
            if (cs_rise && q.st == S_PIN && q.cnt == 6'h00 && q.any
                && !i_page_protected) begin
                d.prog_act = 1'b1;
                d.walk     = 9'h000;
                d.wait_c   = 16'h0000;
                d.page     = q.addr[23:8];
            end
        end else begin
            if (rise) begin
                case (q.st)
                    S_CMD: begin
                        d.sh  = code;
                        d.cnt = 6'(q.cnt + 6'h01);
                        if (cmd_done) begin
                            d.cnt    = 6'h00;
                            d.cmd    = code;
                            d.st     = S_SKIP;
                            d.in_w   = LANE_1;
                            d.out_w  = LANE_1;
                            d.dum    = 4'h0;
                            d.mode   = 1'b0;
                            d.src_st = 1'b0;
                            // while busy only the status read gets through
                            if (!q.prog_act || code == OP_RD_STATUS) begin
                                case (code)
                                    OP_FAST_READ: begin
                                        d.st  = S_ADDR;
                                        d.dum = DUMMY_FAST;
                                    end
                                    OP_DUAL_OUT: begin
                                        d.st    = S_ADDR;
                                        d.dum   = DUMMY_FAST;
                                        d.out_w = LANE_2;
                                    end
                                    OP_QUAD_OUT: begin
                                        if (i_quad_io_enable_bit) begin
                                            d.st    = S_ADDR;
                                            d.dum   = DUMMY_FAST;
                                            d.out_w = LANE_4;
                                        end
                                    end
                                    OP_DUAL_IO: begin
                                        d.st    = S_ADDR;
                                        d.in_w  = LANE_2;
                                        d.out_w = LANE_2;
                                        d.mode  = 1'b1;
                                    end
                                    OP_QUAD_IO: begin
                                        if (i_quad_io_enable_bit) begin
                                            d.st    = S_ADDR;
                                            d.in_w  = LANE_4;
                                            d.out_w = LANE_4;
                                            d.mode  = 1'b1;
                                            d.dum   = DUMMY_QIO;
                                        end
                                    end
                                    OP_SET_WRAP: begin
                                        d.st   = S_ADDR;
                                        d.in_w = LANE_4;
                                    end
                                    OP_PAGE_PROG: begin
                                        if (q.write_enable_latch) d.st = S_ADDR;
                                    end
                                    OP_WR_EN:     d.write_enable_latch = 1'b1;
                                    OP_WR_DIS:    d.write_enable_latch = 1'b0;
                                    OP_RD_STATUS: begin
                                        d.st     = S_DOUT;
                                        d.src_st = 1'b1;
                                    end
                                    default: ;
                                endcase
                            end
                        end
                    end
                    S_ADDR: begin
                        d.addr = shift_in(q.addr, q.in_w, q.dq_s2);
                        d.cnt  = 6'(q.cnt + 6'h01);
                        if (q.cnt == 6'(edges_for(q.in_w, ADDR_BITS) - 6'h01)) begin
                            d.cnt = 6'h00;
                            if (q.cmd == OP_SET_WRAP) d.st = S_WRAP;
                            else if (q.cmd == OP_PAGE_PROG) begin
                                d.st  = S_PIN;
                                d.ld  = '0;
                                d.any = 1'b0;
                            end
                            else if (q.mode) d.st = S_MODE;
                            else if (q.dum != 4'h0) d.st = S_DUMMY;
                            else d.st = S_DOUT;
                        end
                    end
                    S_MODE: begin
                        // mode byte is taken and ignored
                        d.cnt = 6'(q.cnt + 6'h01);
                        if (q.cnt == 6'(edges_for(q.in_w, MODE_BITS) - 6'h01)) begin
                            d.cnt = 6'h00;
                            d.st  = (q.dum != 4'h0) ? S_DUMMY : S_DOUT;
                        end
                    end
                    S_DUMMY: begin
                        d.cnt = 6'(q.cnt + 6'h01);
                        if (q.cnt == {2'b00, 4'(q.dum - 4'h1)}) begin
                            d.cnt = 6'h00;
                            d.st  = S_DOUT;
                        end
                    end
                    S_PIN: begin
                        d.sh  = code;
                        d.cnt = 6'(q.cnt + 6'h01);
                        if (q.cnt == CODE_BITS - 6'h01) begin
                            // low address byte rolls over inside the page
                            d.cnt               = 6'h00;
                            d.pb[q.addr[7:0]]   = code;
                            d.ld[q.addr[7:0]]   = 1'b1;
                            d.addr[7:0]         = 8'(q.addr[7:0] + 8'h01);
                            d.any               = 1'b1;
                        end
                    end
                    S_WRAP: begin
                        d.sh  = {q.sh[3:0], q.dq_s2};
                        d.cnt = 6'(q.cnt + 6'h01);
                        if (q.cnt == WRAP_EDGES - 6'h01) begin
                            // bit 7 and the low nibble are dropped
                            d.wrap = q.sh[2:0];
                            d.st   = S_SKIP;
                        end
                    end
                    default: ;
                endcase
            end
            // output side: new lanes on each falling edge, msb first
            if (fall && q.st == S_DOUT) begin
                if (q.cnt == 6'h00) byte_v = q.src_st ? status : i_rd_data;
                d.dq_o   = lanes(byte_v, q.out_w);
                d.out_sh = 8'(byte_v << q.out_w);
                d.dq_oe  = oe_for(q.out_w);
                d.cnt    = 6'(q.cnt + 6'h01);
                if (q.cnt == 6'(edges_for(q.out_w, CODE_BITS) - 6'h01)) begin
                    d.cnt = 6'h00;
                    if (q.cmd == OP_QUAD_IO && !q.wrap[WRAP_DIS_POS]) begin
                        d.addr[7:0] = (q.addr[7:0] & ~wmask)
                                    | (8'(q.addr[7:0] + 8'h01) & wmask);
                    end else begin
                        d.addr = 24'(q.addr + 24'h000001);
                    end
                end
            end
        end
        // program cycle: hand loaded bytes to the buffer, then settle
        if (q.prog_act) begin
            if (q.walk != PAGE_END) begin
                if (!q.ld[q.walk[7:0]]) d.walk = 9'(q.walk + 9'h001);
                else if (q.fcnt != 2'h2) begin
                    push   = 1'b1;
                    d.walk = 9'(q.walk + 9'h001);
                end
            end else if (q.wait_c == 16'(PROG_WAIT_CYC - 1)) begin
                d.prog_act = 1'b0;
                d.write_enable_latch      = 1'b0;
            end else begin
                d.wait_c = 16'(q.wait_c + 16'h0001);
            end
        end
        // two-entry buffer: a stalled sink holds the walk, nothing is lost
        if (push) begin
            d.fb[q.fwr] = {q.page, q.walk[7:0], q.pb[q.walk[7:0]]};
            d.fwr       = ~q.fwr;
        end
        if (pop) d.frd = ~q.frd;
        d.fcnt = 2'(q.fcnt + {1'b0, push} - {1'b0, pop});
    end

    // ========================================
    // state register
    always_ff @(posedge i_ref_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            q       <= '0;
            q.cs_sy <= 3'h7;
            q.wrap  <= WRAP_RESET;
        end else begin
            q <= d;
        end
    end

    // ========================================
    // outputs
    assign o_dq                 = q.dq_o;
    assign o_dq_oe              = q.dq_oe;
    assign o_flash_addr         = q.addr;
    assign o_prog_valid         = q.fcnt != 2'h0;
    assign o_prog_addr          = q.fb[q.frd][31:8];
    assign o_prog_data          = q.fb[q.frd][7:0];
    assign o_busy               = q.prog_act;
    assign o_write_enable_latch = q.write_enable_latch;
    assign o_wrap_setting       = q.wrap;

    // ========================================
    // checks
    default clocking cb @(posedge i_ref_clk); endclocking
    default disable iff (!i_rst_b);

    qe_gate_a: assert property (cmd_done && !i_quad_io_enable_bit && !q.prog_act
        && (code == OP_QUAD_OUT || code == OP_QUAD_IO) |=> q.st == S_SKIP)
        else $error("quad read accepted without quad enable");
    pp_wel_a: assert property (cmd_done && code == OP_PAGE_PROG && !q.write_enable_latch
        |=> q.st == S_SKIP)
        else $error("page program accepted without write enable");
    rdsr_busy_a: assert property (cmd_done && code == OP_RD_STATUS
        |=> q.st == S_DOUT && q.src_st)
        else $error("status read not accepted");
    dummy_quiet_a: assert property (q.st == S_DUMMY |-> q.dq_oe == 4'h0)
        else $error("data lines driven during dummy clocks");
    page_wrap_a: assert property (rise && q.st == S_PIN && q.cnt == 6'h07
        |=> q.addr[23:8] == $past(q.addr[23:8])
            && q.addr[7:0] == 8'($past(q.addr[7:0]) + 8'h01))
        else $error("program address left the page");
    boundary_a: assert property (cs_rise && q.st == S_PIN && q.cnt != 6'h00
        |=> !q.prog_act)
        else $error("program started off a byte boundary");
    busy_done_a: assert property ($fell(q.prog_act) |-> !q.write_enable_latch)
        else $error("write enable latch left set after program");
    wrap_keep_a: assert property (fall && q.st == S_DOUT && q.cmd == OP_QUAD_IO
        && !q.wrap[WRAP_DIS_POS] |=> (q.addr[7:0] & ~wmask) == ($past(q.addr[7:0]) & ~wmask))
        else $error("wrapped read left its section");
    msb_first_a: assert property (fall && q.st == S_DOUT && q.cnt == 6'h00
        && q.out_w == LANE_1 && !q.src_st |=> q.dq_o[1] == $past(i_rd_data[7]))
        else $error("first data bit is not the msb");

    quad_read_c: cover property (q.st == S_DOUT && q.cmd == OP_QUAD_IO && q.dq_oe == OE_QUAD);
    prog_start_c: cover property ($rose(q.prog_act));
    wrap_set_c: cover property (q.st == S_WRAP ##1 q.st == S_SKIP);
    poll_busy_c: cover property (q.prog_act && q.src_st && q.st == S_DOUT);
endmodule

// [design/spi_flash_pkg.sv]
// constants and types shared by the serial flash read and program logic
package spi_flash_pkg;
    // ========================================
    // command codes
    localparam logic [7:0] OP_FAST_READ = 8'h0B;
    localparam logic [7:0] OP_DUAL_OUT  = 8'h3B;
    localparam logic [7:0] OP_QUAD_OUT  = 8'h6B;
    localparam logic [7:0] OP_DUAL_IO   = 8'hBB;
    localparam logic [7:0] OP_QUAD_IO   = 8'hEB;
    localparam logic [7:0] OP_SET_WRAP  = 8'h77;
    localparam logic [7:0] OP_PAGE_PROG = 8'h02;
    localparam logic [7:0] OP_WR_EN     = 8'h06;
    localparam logic [7:0] OP_WR_DIS    = 8'h04;
    localparam logic [7:0] OP_RD_STATUS = 8'h05;
    // ========================================
    // field sizes, lane widths and dummy counts
    localparam logic [5:0] CODE_BITS    = 6'h08;
    localparam logic [5:0] ADDR_BITS    = 6'h18;
    localparam logic [5:0] MODE_BITS    = 6'h08;
    localparam logic [5:0] WRAP_EDGES   = 6'h02;
    localparam logic [2:0] LANE_1       = 3'h1;
    localparam logic [2:0] LANE_2       = 3'h2;
    localparam logic [2:0] LANE_4       = 3'h4;
    localparam logic [3:0] DUMMY_FAST   = 4'h8;
    localparam logic [3:0] DUMMY_QIO    = 4'h4;
    localparam logic [3:0] OE_SINGLE    = 4'h2;
    localparam logic [3:0] OE_DUAL      = 4'h3;
    localparam logic [3:0] OE_QUAD      = 4'hF;
    // ========================================
    // wrap setting {length[1:0], disable}; disable set out of reset
    localparam logic [2:0] WRAP_RESET   = 3'h1;
    localparam int         WRAP_DIS_POS = 0;
    localparam logic [7:0] WRAP_MIN     = 8'h08;
    // status byte positions
    localparam int         ST_BUSY_POS  = 0;
    localparam int         ST_WEL_POS   = 1;
    localparam logic [8:0] PAGE_END     = 9'h100;

    typedef enum logic [2:0] {
        S_CMD, S_ADDR, S_MODE, S_DUMMY, S_DOUT, S_PIN, S_WRAP, S_SKIP
    } phase_e;
endpackage

// [tb/spi_host.sv]
// host side of the flash link, bit-banged from the system clock
`timescale 1ns/10ps
module spi_host (
    input  wire logic       i_ref_clk,
    input  wire logic [3:0] i_dq,
    output logic            o_sclk,
    output logic            o_cs_b,
    output logic      [3:0] o_dq,
    output logic      [3:0] o_dq_oe
);
    // idle link: clock low, deselected, lines released
    initial begin
        o_sclk  = 1'b0;
        o_cs_b  = 1'b1;
        o_dq    = 4'h0;
        o_dq_oe = 4'h0;
    end
    // ========================================
    // one serial clock; half period of 5 keeps clear of the 2-FF sync delay
    task automatic tick(input logic [3:0] v, input logic [3:0] oe, output logic [3:0] q);
        o_dq    <= v;
        o_dq_oe <= oe;
        repeat (5) @(posedge i_ref_clk);
        q = i_dq;
        o_sclk <= 1'b1;
        repeat (5) @(posedge i_ref_clk);
        o_sclk <= 1'b0;
    endtask
    // shift a value out msb first over ln lines, the highest driven line leading
    task automatic send(input logic [31:0] v, input int bits, input int ln);
        logic [3:0] q;
        logic [3:0] m;
        m = (ln == 4) ? 4'hF : (ln == 2) ? 4'h3 : 4'h1;
        for (int i = bits - ln; i >= 0; i -= ln) tick(4'(v >> i) & m, m, q);
    endtask
    // all lines released while listening, dummies included
    task automatic rx(output logic [7:0] b, input int clks, input int ln);
        logic [3:0] q;
        for (int i = 0; i < clks; i++) begin
            tick(4'h0, 4'h0, q);
            b = (ln == 4) ? {b[3:0], q} : (ln == 2) ? {b[5:0], q[1:0]} : {b[6:0], q[1]};
        end
    endtask
    // select edges, each followed by 6 clocks to clear the sync delay
    task automatic sel(input logic lvl);
        o_cs_b <= lvl;
        repeat (6) @(posedge i_ref_clk);
    endtask
endmodule

// [tb/tb_spi_flash_cmd.sv]
// self-checking bench for the flash command block
`timescale 1ns/10ps
`define CHK(a, e) begin n_tests++; if ((a) !== (e)) begin error_cnt++; \
    $display("unexpected %0t got %h want %h", $time, a, e); end end
module tb_spi_flash_cmd
    import spi_flash_pkg::*;
;
    logic        clk;
    logic        rst_b;
    logic        qe;
    logic        rdy;
    logic [7:0]  rd_data;
    logic [3:0]  last = 4'h0;
    wire  [3:0]  dq_w;
    logic [3:0]  dut_dq, dut_oe, h_dq, h_oe;
    logic        sclk, cs_b, prot, pv, busy, write_enable_latch;
    logic [23:0] fa, pa;
    logic [7:0]  pd, st;
    logic [2:0]  wset;
    logic [31:0] got [$];
    int          error_cnt = 0;
    int          n_tests = 0;
    logic [7:0]  ops [5] = '{OP_FAST_READ, OP_DUAL_OUT, OP_QUAD_OUT, OP_DUAL_IO, OP_QUAD_IO};
    int          als [5] = '{1, 1, 1, 2, 4};
    int          dms [5] = '{8, 8, 8, 0, 4};
    int          dls [5] = '{1, 2, 4, 2, 4};
    logic [31:0] ex [4] = '{32'h000000A2, 32'h000001A3, 32'h0000FEA0, 32'h0000FFA1};
    // ========================================
    // a released line shows the inverse of its last level, so stale data cannot pass
    assign dq_w = (dut_oe & dut_dq) | (~dut_oe & h_oe & h_dq) | (~dut_oe & ~h_oe & ~last);
    assign prot = (fa[23:16] == 8'hFF);
    function automatic logic [7:0] mem(input logic [23:0] a);
        return a[7:0] ^ a[15:8] ^ 8'h3C;
    endfunction
    // array model, program sink and contention watch
    always @(posedge clk) begin
        rd_data <= mem(fa);
        last <= dq_w;
        if (pv === 1'b1 && rdy) got.push_back({pa, pd});
        `CHK(dut_oe & h_oe, 4'h0)
    end
    initial begin
        clk = 1'b0;
        forever #50 clk = ~clk;
    end
    spi_flash_cmd #(.PROG_WAIT_CYC(2)) DUT (.i_ref_clk(clk), .i_rst_b(rst_b), .i_sclk(sclk),
        .i_cs_b(cs_b), .i_dq(dq_w), .o_dq(dut_dq), .o_dq_oe(dut_oe),
        .i_quad_io_enable_bit(qe), .i_page_protected(prot), .o_flash_addr(fa),
        .i_rd_data(rd_data), .o_prog_valid(pv), .o_prog_addr(pa), .o_prog_data(pd),
        .i_prog_ready(rdy), .o_busy(busy), .o_write_enable_latch(write_enable_latch), .o_wrap_setting(wset));
    spi_host h (.i_ref_clk(clk), .i_dq(dq_w), .o_sclk(sclk), .o_cs_b(cs_b), .o_dq(h_dq),
        .o_dq_oe(h_oe));
    // ========================================
    // read: code, address, mode byte on i/o reads, dummies, n bytes
    task automatic rd(input logic [7:0] op, input logic [23:0] a, input int al, input int dm,
                      input int dl, input int n, input logic [23:0] m, input logic ok);
        logic [7:0]  b;
        logic [23:0] x;
        h.sel(1'b0);
        h.send(op, 8, 1);
        h.send(a, 24, al);
        if (al > 1) h.send(32'h0, 8, al); // mode byte ignored
        h.rx(b, dm, 1);
        `CHK(dut_oe, 4'h0)
        for (int i = 0; i < n; i++) begin
            h.rx(b, 8 / dl, dl);
            x = (a & ~m) | ((a + i) & m);
            if (ok) `CHK(b, mem(x))
            else `CHK(dut_oe, 4'h0)
        end
        h.sel(1'b1);
    endtask
    task automatic cmd(input logic [7:0] op);
        h.sel(1'b0);
        h.send(op, 8, 1);
        h.sel(1'b1);
    endtask
    task automatic wrap(input logic [7:0] w);
        h.sel(1'b0);
        h.send(OP_SET_WRAP, 8, 1);
        h.send(32'h0, 24, 4);
        h.send(w, 8, 4);
        h.sel(1'b1);
    endtask
    // tail adds loose bits after the last byte
    task automatic pp(input logic [23:0] a, input int n, input int tail);
        h.sel(1'b0);
        h.send(OP_PAGE_PROG, 8, 1);
        h.send(a, 24, 1);
        for (int i = 0; i < n; i++) h.send(32'(8'hA0 + i), 8, 1);
        h.send(32'h0, tail, 1);
        h.sel(1'b1);
    endtask
    task automatic finish_test();
        if (error_cnt == 0 && n_tests > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask
    // watchdog well past the expected 10000 cycles
    initial begin
        repeat (60000) @(posedge clk);
        error_cnt++;
        finish_test();
    end
    initial begin
        rst_b = 1'b0;
        qe    = 1'b0;
        rdy   = 1'b1;
        repeat (10) @(posedge clk);
        rst_b <= 1'b1;
        repeat (3) @(posedge clk);
        `CHK(wset, WRAP_RESET)
        `CHK({busy, write_enable_latch}, 2'b00)
        rd(OP_QUAD_OUT, 24'h10, 1, 8, 4, 1, 24'hFFFFFF, 1'b0);
        rd(OP_QUAD_IO, 24'h10, 4, 4, 4, 1, 24'hFFFFFF, 1'b0);
        qe <= 1'b1;
        for (int k = 0; k < 5; k++) rd(ops[k], 24'hFE, als[k], dms[k], dls[k], 3, '1, 1'b1);
        for (int L = 0; L < 4; L++) begin
            wrap({1'b1, 2'(L), 1'b0, 4'hF});
            `CHK(wset, {2'(L), 1'b0})
            rd(OP_QUAD_IO, {8'h0, 8'(L), 8'hF9}, 4, 4, 4, (8 << L) + 2, 24'((8 << L) - 1), 1'b1);
        end
        wrap(8'h10);
        `CHK(wset, 3'h1)
        pp(24'hFE, 1, 0);
        `CHK(busy, 1'b0)
        cmd(OP_WR_EN);
        `CHK(write_enable_latch, 1'b1)
        pp(24'hFE, 1, 4);
        `CHK(busy, 1'b0)
        pp(24'hFF0010, 1, 0);
        `CHK(busy, 1'b0)
        cmd(OP_WR_EN);
        rdy <= 1'b0;
        pp(24'hFE, 4, 0);
        `CHK(busy, 1'b1)
        h.sel(1'b0);
        h.send(OP_RD_STATUS, 8, 1);
        h.rx(st, 8, 1);
        h.sel(1'b1);
        `CHK(st, 8'h03)
        `CHK(pv, 1'b1)
        rdy <= 1'b1;
        for (int i = 0; i < 2000 && busy !== 1'b0; i++) @(posedge clk);
        `CHK({busy, write_enable_latch}, 2'b00)
        `CHK(got.size(), 4)
        foreach (ex[i]) `CHK(got[i], ex[i])
        finish_test();
    end
endmodule
